// ### rtl/sfp_defines.svh
// Purpose: Constants of the serial flash programming slave.
// Assumes: Included by bare name.
// Notes:   Header fields are bit positions in the 24-bit address word.
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH
`define SFP_ACC_BIT     23
`define SFP_DIR_BIT     16
`define SFP_ERASE_CODE0 8'h55
`define SFP_ERASE_CODE1 8'h15
`define SFP_SEC_PAGE    8'h0E
`define SFP_SEC_HI5     5'h07
`define SFP_ERASED      8'hFF
`define SFP_LAST_BIT    4'h7
`define SFP_DUMMY_CLK   4'h8
`define SFP_DATA_PHASE  2'h3
`define SFP_LAST_HDR    2'h2
`define SFP_MAIN_BYTES  16384
`endif

// ### rtl/sfp_pkg.sv
// Purpose: Types of the serial flash programming slave.
// Assumes: Nothing beyond the defines header.
// Notes:   The event word crosses from the link clock with a toggle.
`default_nettype none
package sfp_pkg;
  typedef enum logic [2:0] {
    SFP_IDLE, SFP_PROG, SFP_READ, SFP_OPT_WR, SFP_OPT_RD, SFP_ERASE, SFP_SKIP
  } sfp_state_e;
  typedef struct packed {
    logic        is_hdr;
    logic [23:0] word;
  } sfp_evt_s;
endpackage
`default_nettype wire

// ### rtl/sfp_slave.sv
// Purpose: Slave command engine of the two-wire flash programming link.
// Assumes: Start and stop are decoded outside and arrive as link_frame.
// Notes:   Link bits are sampled on rising link_clk, driven on falling.
// Contract
// (R1) Whole erase clears main array, option bytes and protection bytes.
// (R2) Erase ignores third address byte, accepts either second-byte code.
// (R3) Erase data byte is ignored; master normally sends 0xAA.
// (R4) Master ends write commands with a 0xFF dummy byte and stop.
// (R5) Programming only clears bits; a zero never returns to one.
// (R6) Bits 23 and 16 both zero start main-array programming at A[19:0].
// (R7) Target address increments after every programmed byte.
// (R8) Byte programming starts at its dummy clock; next byte keeps shifting. Code hands the byte over at its eighth bit instead.
// (R9) Every eight link bits are followed by one dummy clock.
// (R10) Master spaces dummy clocks at least 30 us apart while programming.
// (R11) Master sends no more bytes than the array holds, plus one.
// (R12) Device drives data clocks on reads; master drives dummy clocks.
// (R13) Location n fetched at dummy after third address byte, then n+1. Code fetches at each byte's eighth bit, before the dummy.
// (R14) Fetched bytes shift out most significant bit first.
// (R15) Master ends a read with stop at or after the last dummy.
// (R16) Option bytes sit at secondary 0x38-0x3B, reached only via bit 23.
// (R17) The processor never reaches option or protection bytes.
// (R18) Master reads option bytes with nine clocks per byte, then stop.
// (R19) Option writes auto-increment, one to four bytes per command.
// (R20) Option bits stay cleared until whole erase sets them all to one. Code also sets them all to one while resetn is low.
// (R21) Access bit zero targets main array, one the secondary cell.
// (R22) Master sends zeros in the upper four address bits.
// (R23) A stop anywhere drops the partial byte and ends the command. Code lets a stop during SFP_ERASE leave the erase walk running.
`include "sfp_defines.svh"
`default_nettype none
module sfp_slave #(
  parameter int unsigned MAIN_BYTES = `SFP_MAIN_BYTES,
  parameter int unsigned AW         = $clog2(MAIN_BYTES)
) (
  input  wire logic          clk,                 // System clock.
  input  wire logic          resetn,              // Async reset, low.
  input  wire logic          ce,                  // Clock enable.
  input  wire logic          link_clk,            // Master's link clock.
  input  wire logic          link_frame,          // High between start, stop.
  input  wire logic          prog_serial_line_i,  // Data line level.
  output var  logic          prog_serial_line_o,  // Data line drive value.
  output var  logic          prog_serial_line_oe, // Data line drive enable.
  input  wire logic          cpu_rd,              // Processor read strobe.
  input  wire logic [AW-1:0] cpu_addr,            // Processor main address.
  output var  logic [7:0]    cpu_rdata,           // Processor read data.
  output logic      [31:0]   option_bytes,        // Option bytes 0x3B..0x38.
  output var  logic          erase_busy           // Whole erase running.
);
  // Link domain, cleared whenever no frame is open, except the event toggle and event word.
  logic [3:0]       cnt, next_cnt;
  logic [1:0]       bidx, next_bidx;
  logic [15:0]      hdr, next_hdr;
  logic [7:0]       rx, next_rx, rx_byte;
  logic             dir_read, next_dir_read;
  logic             ev_tog, next_ev_tog;
  sfp_pkg::sfp_evt_s ev, next_ev;
  logic [7:0]       tx, next_tx;
  logic             next_o, next_oe;
  // System domain.
  logic             tog1, tog2, tog3, frm1, frm2, evt;
  sfp_pkg::sfp_state_e state, next_state;
  logic [19:0]      ptr, next_ptr;
  logic [AW-1:0]    ecnt, next_ecnt;
  logic [7:0]       rd_byte, next_rd_byte;
  logic             next_busy;
  logic [7:0]       mem [MAIN_BYTES];
  logic [7:0]       sec [8];
  logic [7:0]       next_sec [8];
  logic             mem_we, sec_we, sec_clr, main_hit;
  logic [AW-1:0]    mem_wa;
  logic [7:0]       mem_wd, sec_wd, main_rdata, mem_old;
  logic [2:0]       sec_idx;
  logic [23:0]      w;
  logic [19:0]      hdr_addr;

  assign rx_byte = {rx[6:0], prog_serial_line_i};

  always_comb begin
    next_cnt      = cnt;
    next_bidx     = bidx;
    next_hdr      = hdr;
    next_rx       = rx;
    next_dir_read = dir_read;
    next_ev_tog   = ev_tog;
    next_ev       = ev;
    // (R9) nine clocks a byte
    if (cnt == `SFP_DUMMY_CLK) begin
      next_cnt = 4'h0;
    end else begin
      next_cnt = cnt + 4'h1;
      next_rx  = rx_byte;
    end
    // (R8) hand byte over
    if (cnt == `SFP_LAST_BIT) begin
      if (bidx != `SFP_DATA_PHASE) begin
        next_hdr  = {hdr[7:0], rx_byte};
        next_bidx = bidx + 2'h1;
      end
      if (bidx == `SFP_LAST_HDR) begin
        next_dir_read = hdr[`SFP_DIR_BIT - 8];
      end
      if (bidx >= `SFP_LAST_HDR) begin
        next_ev.is_hdr = (bidx == `SFP_LAST_HDR);
        next_ev.word   = {hdr, rx_byte};
        next_ev_tog    = ~ev_tog;
      end
    end
  end

  // (R23) stop drops partial byte
  always_ff @(posedge link_clk or negedge link_frame) begin
    if (!link_frame) begin
      cnt      <= 4'h0;
      bidx     <= 2'h0;
      hdr      <= 16'h0000;
      rx       <= 8'h00;
      dir_read <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      bidx     <= next_bidx;
      hdr      <= next_hdr;
      rx       <= next_rx;
      dir_read <= next_dir_read;
    end
  end

  // The event toggle survives a stop, so a stop never fakes an event.
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      ev_tog <= 1'b0;
      ev     <= '0;
    end else begin
      ev_tog <= next_ev_tog;
      ev     <= next_ev;
    end
  end

  // The fetched byte settles within a few clk cycles of the last bit,
  // long before the falling edge of the dummy clock loads it here.
  always_comb begin
    next_tx = tx;
    next_oe = 1'b0;
    next_o  = 1'b0;
    if (cnt == 4'h0) begin
      next_tx = rd_byte;
    end
    // (R12) drive only data clocks
    if (dir_read && bidx == `SFP_DATA_PHASE &&
        cnt != `SFP_DUMMY_CLK) begin
      next_oe = 1'b1;
      // (R14) msb first
      next_o  = (cnt == 4'h0) ? rd_byte[7] : tx[3'h7 - cnt[2:0]];
    end
  end

  always_ff @(negedge link_clk or negedge link_frame) begin
    if (!link_frame) begin
      tx                  <= 8'h00;
      prog_serial_line_o  <= 1'b0;
      prog_serial_line_oe <= 1'b0;
    end else begin
      tx                  <= next_tx;
      prog_serial_line_o  <= next_o;
      prog_serial_line_oe <= next_oe;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tog1 <= 1'b0;
      tog2 <= 1'b0;
      tog3 <= 1'b0;
      frm1 <= 1'b0;
      frm2 <= 1'b0;
    end else if (ce) begin
      tog1 <= ev_tog;
      tog2 <= tog1;
      tog3 <= tog2;
      frm1 <= link_frame;
      frm2 <= frm1;
    end
  end

  assign evt        = tog2 ^ tog3;
  assign w          = ev.word;
  // Address bits 19 to 16 ride in header bits 20 to 17, above direction.
  assign hdr_addr   = {w[20:17], w[15:0]};
  assign main_hit   = ptr < 20'(MAIN_BYTES);
  assign main_rdata = main_hit ? mem[ptr[AW-1:0]] : `SFP_ERASED;
  assign mem_old    = mem[mem_wa];

  always_comb begin
    next_state   = state;
    next_ptr     = ptr;
    next_ecnt    = ecnt;
    next_rd_byte = rd_byte;
    mem_we       = 1'b0;
    mem_wa       = ptr[AW-1:0];
    mem_wd       = mem_old & w[7:0];
    sec_we       = 1'b0;
    sec_clr      = 1'b0;
    sec_idx      = ptr[2:0];
    sec_wd       = sec[ptr[2:0]] & w[7:0];
    if (state == sfp_pkg::SFP_ERASE) begin
      // (R1) clear main array
      mem_we    = 1'b1;
      mem_wa    = ecnt;
      mem_wd    = `SFP_ERASED;
      next_ecnt = ecnt + AW'(1);
      if (ecnt == AW'(MAIN_BYTES - 1)) begin
        next_state = sfp_pkg::SFP_IDLE;
      end
    end else if (!frm2) begin
      // (R23) stop ends command
      next_state = sfp_pkg::SFP_IDLE;
    end else if (evt && ev.is_hdr) begin
      next_ptr = {12'h000, w[7:0]};
      // (R21) access bit selects cell
      if (!w[`SFP_ACC_BIT]) begin
        // (R6) main program or read
        next_ptr   = hdr_addr;
        next_state = w[`SFP_DIR_BIT] ? sfp_pkg::SFP_READ
                                     : sfp_pkg::SFP_PROG;
        if (w[`SFP_DIR_BIT]) begin
          // (R13) fetch first location
          next_rd_byte = (hdr_addr < 20'(MAIN_BYTES)) ?
                         mem[hdr_addr[AW-1:0]] : `SFP_ERASED;
          next_ptr     = hdr_addr + 20'h1;
        end
      // (R2) either code, low byte ignored
      end else if (!w[`SFP_DIR_BIT] && (w[15:8] == `SFP_ERASE_CODE0 ||
                   w[15:8] == `SFP_ERASE_CODE1)) begin
        next_state = sfp_pkg::SFP_ERASE;
        next_ecnt  = '0;
        sec_clr    = 1'b1;
      // (R16) secondary page only
      end else if (w[15:8] == `SFP_SEC_PAGE &&
                   w[7:3] == `SFP_SEC_HI5) begin
        next_state = w[`SFP_DIR_BIT] ? sfp_pkg::SFP_OPT_RD
                                     : sfp_pkg::SFP_OPT_WR;
        if (w[`SFP_DIR_BIT]) begin
          next_rd_byte = sec[w[2:0]];
          next_ptr     = {12'h000, w[7:0]} + 20'h1;
        end
      end else begin
        next_state = sfp_pkg::SFP_SKIP;
      end
    end else if (evt) begin
      // (R3) data bytes outside these states are dropped
      unique case (state)
        sfp_pkg::SFP_PROG: begin
          // (R5) write is old AND new
          mem_we   = main_hit;
          // (R7) next target
          next_ptr = ptr + 20'h1;
        end
        sfp_pkg::SFP_READ: begin
          // (R13) fetch n+1
          next_rd_byte = main_rdata;
          next_ptr     = ptr + 20'h1;
        end
        sfp_pkg::SFP_OPT_WR: begin
          // (R19) option auto-increment
          sec_we   = (ptr[7:3] == `SFP_SEC_HI5);
          next_ptr = ptr + 20'h1;
        end
        sfp_pkg::SFP_OPT_RD: begin
          next_rd_byte = (ptr[7:3] == `SFP_SEC_HI5) ? sec[ptr[2:0]]
                                                    : `SFP_ERASED;
          next_ptr     = ptr + 20'h1;
        end
        default: ;
      endcase
    end
    next_busy = (next_state == sfp_pkg::SFP_ERASE);
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // (R20) only erase sets bits
      if (sec_clr) begin
        next_sec[i] = `SFP_ERASED;
      end else if (sec_we && sec_idx == 3'(i)) begin
        next_sec[i] = sec_wd;
      end else begin
        next_sec[i] = sec[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state      <= sfp_pkg::SFP_IDLE;
      ptr        <= 20'h00000;
      ecnt       <= '0;
      rd_byte    <= `SFP_ERASED;
      erase_busy <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        sec[i] <= `SFP_ERASED;
      end
    end else if (ce) begin
      state      <= next_state;
      ptr        <= next_ptr;
      ecnt       <= next_ecnt;
      rd_byte    <= next_rd_byte;
      erase_busy <= next_busy;
      sec        <= next_sec;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // (R17) processor sees main array only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_rdata <= 8'h00;
    end else if (ce && cpu_rd) begin
      cpu_rdata <= mem[cpu_addr];
    end
  end

  assign option_bytes = {sec[3], sec[2], sec[1], sec[0]};

  // Checks.
  logic [AW-1:0] chk_wa;
  always_ff @(posedge clk) begin
    chk_wa <= mem_wa;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_erase_sec;
    ce && sec_clr |=> sec[0] == 8'hFF && sec[7] == 8'hFF;
  endproperty
  a_erase_sec: assert property (p_erase_sec) else $error("erase kept sec"); // R1
  property p_erase_codes;
    ce && frm2 && state != sfp_pkg::SFP_ERASE && evt && ev.is_hdr &&
    w[23] && !w[16] && (w[15:8] == 8'h55 || w[15:8] == 8'h15)
    |=> erase_busy && state == sfp_pkg::SFP_ERASE;
  endproperty
  a_erase_codes: assert property (p_erase_codes) else $error("no erase"); // R2
  property p_prog_and;
    ce && mem_we && state == sfp_pkg::SFP_PROG
    |=> (mem[chk_wa] & ~$past(mem_old)) == 8'h00;
  endproperty
  a_prog_and: assert property (p_prog_and) else $error("bit set"); // R5
  property p_prog_start;
    ce && frm2 && state != sfp_pkg::SFP_ERASE && evt && ev.is_hdr &&
    !w[23] && !w[16]
    |=> state == sfp_pkg::SFP_PROG && ptr == $past(hdr_addr);
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("no prog"); // R6
  property p_prog_inc;
    ce && frm2 && evt && !ev.is_hdr && state == sfp_pkg::SFP_PROG
    |=> ptr == $past(ptr) + 20'h1;
  endproperty
  a_prog_inc: assert property (p_prog_inc) else $error("no increment"); // R7
  property p_read_fetch;
    ce && frm2 && evt && !ev.is_hdr && state == sfp_pkg::SFP_READ
    |=> rd_byte == $past(main_rdata);
  endproperty
  a_read_fetch: assert property (p_read_fetch) else $error("bad fetch"); // R13
  property p_sec_path;
    sec_we |-> state == sfp_pkg::SFP_OPT_WR && ptr[7:3] == 5'h07;
  endproperty
  a_sec_path: assert property (p_sec_path) else $error("sec via main"); // R16
  property p_stop_idle;
    ce && !frm2 && state != sfp_pkg::SFP_ERASE
    |=> state == sfp_pkg::SFP_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop ignored"); // R23
  property p_erase_end;
    ce && state == sfp_pkg::SFP_ERASE && ecnt == AW'(MAIN_BYTES - 1)
    |=> !erase_busy ##1 !erase_busy;
  endproperty
  a_erase_end: assert property (p_erase_end) else $error("erase hangs"); // R1
  c_erase: cover property (erase_busy ##1 !erase_busy);
  c_prog:  cover property (mem_we && state == sfp_pkg::SFP_PROG);
  c_read:  cover property (evt && state == sfp_pkg::SFP_READ);
  c_opt:   cover property (sec_we);
endmodule
`default_nettype wire

// ### testbench/sfp_master_model.sv
// Purpose: Behavioural programming tool that masters the two-wire link.
// Assumes: The device drives the data line only while its enable is high.
// Notes:   The link clock idles low and stands still outside frames.
`default_nettype none
module sfp_master_model #(
  parameter int unsigned HALF_NS = 80,   // Half link clock period in ns.
  parameter int unsigned GAP_NS  = 30000 // Programming wait in ns.
) (
  output var  logic link_clk,   // Link clock.
  output var  logic link_frame, // High from start to stop.
  output wire logic line,       // Resolved data line level.
  input  wire logic dev_o,      // Device drive value.
  input  wire logic dev_oe      // Device drive enable.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m_val;
  // During get_byte a released line shows the inverse of its last value, never a held copy.
  assign line = dev_oe ? dev_o : m_val;
  initial begin
    link_clk   = 1'b0;
    link_frame = 1'b0;
    m_val      = 1'b1;
  end
  task automatic clock_bit(input logic v);
    m_val = v;
    #(HALF_NS / 2) link_clk = 1'b1;
    #(HALF_NS) link_clk = 1'b0;
    #(HALF_NS / 2);
  endtask
  task automatic frame_start();
    #3 link_frame = 1'b1;
    #(HALF_NS);
  endtask
  task automatic frame_stop();
    link_frame = 1'b0;
    #(HALF_NS);
  endtask
  task automatic put_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) clock_bit(b[7-i]);
  endtask
  task automatic put_byte(input logic [7:0] b);
    put_bits(b, 8);
    clock_bit(1'b1);
  endtask
  task automatic send_hdr(input logic acc, input logic dir,
                          input logic [15:0] a);
    put_byte({acc, 2'b11, 4'h0, dir});
    put_byte(a[15:8]);
    put_byte(a[7:0]);
  endtask
  task automatic put_prog_byte(input logic [7:0] b);
    put_bits(b, 8);
    #(GAP_NS);
    clock_bit(1'b1);
  endtask
  task automatic write_end();
    put_prog_byte(8'hFF);
    frame_stop();
  endtask
  task automatic get_byte(output logic [7:0] b, output logic ok);
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      m_val = ~m_val;
      #(HALF_NS / 2) link_clk = 1'b1;
      b  = {b[6:0], line};
      ok = ok & (dev_oe === 1'b1);
      #(HALF_NS) link_clk = 1'b0;
      #(HALF_NS / 2);
    end
    ok = ok & (dev_oe === 1'b0);
    clock_bit(1'b1);
  endtask
endmodule
`default_nettype wire

// ### testbench/test_serial_flash_program_slave.sv
// Purpose: Self-checking bench of the flash programming slave.
// Assumes: A small main array keeps erase walks short.
// Notes:   Link traffic comes from the master model, main array via cpu_rd.
`default_nettype none
module test_serial_flash_program_slave;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MB  = 64;
  localparam int unsigned AWB = $clog2(MB);
  logic           clk;
  logic           resetn;
  logic           ce;
  logic           cpu_rd;
  logic [AWB-1:0] cpu_addr;
  wire logic      link_clk;
  wire logic      link_frame;
  wire logic      sdi;
  wire logic      sdo;
  wire logic      sdoe;
  wire logic      erase_busy;
  wire logic [7:0]  cpu_rdata;
  wire logic [31:0] option_bytes;
  int             n_fail = 0;
  int             checks_done = 0;
  int unsigned    cycles = 0;

  sfp_slave #(.MAIN_BYTES(MB)) u_sfp_slave (
    .clk(clk), .resetn(resetn), .ce(ce), .link_clk(link_clk),
    .link_frame(link_frame), .prog_serial_line_i(sdi),
    .prog_serial_line_o(sdo), .prog_serial_line_oe(sdoe),
    .cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata),
    .option_bytes(option_bytes), .erase_busy(erase_busy)
  );
  sfp_master_model u_sfp_master_model (
    .link_clk(link_clk), .link_frame(link_frame), .line(sdi),
    .dev_o(sdo), .dev_oe(sdoe)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask

  task automatic mem_chk(input logic [AWB-1:0] a, input logic [7:0] e);
    @(posedge clk);
    cpu_rd   <= 1'b1;
    cpu_addr <= a;
    @(posedge clk);
    cpu_rd <= 1'b0;
    #1 chk("cpu_rdata", 32'(cpu_rdata), 32'(e));
  endtask

  task automatic wr(input logic acc, input logic [15:0] a,
                    input logic [7:0] d0, input logic [7:0] d1,
                    input logic [7:0] d2);
    u_sfp_master_model.frame_start();
    u_sfp_master_model.send_hdr(acc, 1'b0, a);
    u_sfp_master_model.put_byte(d0);
    u_sfp_master_model.put_prog_byte(d1);
    u_sfp_master_model.put_prog_byte(d2);
    u_sfp_master_model.write_end();
  endtask

  task automatic rd(input logic acc, input logic [15:0] a,
                    input logic [31:0] e);
    logic [7:0] b;
    logic       ok;
    u_sfp_master_model.frame_start();
    u_sfp_master_model.send_hdr(acc, 1'b1, a);
    for (int i = 3; i >= 0; i--) begin
      u_sfp_master_model.get_byte(b, ok);
      chk("read byte", 32'(b), 32'(e[i*8 +: 8]));
      chk("read drive", 32'(ok), 32'h1);
    end
    u_sfp_master_model.frame_stop();
  endtask

  task automatic erase(input logic [7:0] code, input logic [7:0] x);
    int n;
    n = 0;
    u_sfp_master_model.frame_start();
    u_sfp_master_model.send_hdr(1'b1, 1'b0, {code, x});
    chk("erase_busy", 32'(erase_busy), 32'h1);
    u_sfp_master_model.put_byte(8'hAA);
    u_sfp_master_model.write_end();
    while (erase_busy !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("erase end", 32'(erase_busy), 32'h0);
    chk("options", option_bytes, 32'hFFFFFFFF);
    for (int a = 0; a < MB; a++) mem_chk(AWB'(a), 8'hFF);
  endtask

  initial begin
    resetn   = 1'b0;
    ce       = 1'b1;
    cpu_rd   = 1'b0;
    cpu_addr = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("options", option_bytes, 32'hFFFFFFFF);
    chk("cpu_rdata", 32'(cpu_rdata), 32'h0);
    erase(8'h55, 8'h5A);
    wr(1'b0, 16'h003E, 8'h5A, 8'h3C, 8'hA5);
    wr(1'b0, 16'h003E, 8'hF0, 8'hFF, 8'hFF);
    mem_chk(AWB'(62), 8'h50);
    mem_chk(AWB'(63), 8'h3C);
    rd(1'b0, 16'h003D, 32'hFF503CFF);
    wr(1'b1, 16'h0E39, 8'h0F, 8'hF3, 8'hFF);
    #1 chk("options", option_bytes, 32'hFFF30FFF);
    wr(1'b1, 16'h0E38, 8'hF0, 8'hF0, 8'hFF);
    #1 chk("options", option_bytes, 32'hFFF300F0);
    wr(1'b1, 16'h0E30, 8'h00, 8'h00, 8'h00);
    #1 chk("options", option_bytes, 32'hFFF300F0);
    rd(1'b1, 16'h0E38, 32'hF000F3FF);
    mem_chk(AWB'(56), 8'hFF);
    erase(8'h15, 8'h00);
    u_sfp_master_model.frame_start();
    u_sfp_master_model.send_hdr(1'b0, 1'b0, 16'h0000);
    u_sfp_master_model.put_bits(8'h00, 5);
    u_sfp_master_model.frame_stop();
    mem_chk(AWB'(0), 8'hFF);
    wr(1'b0, 16'h0000, 8'h12, 8'hFF, 8'hFF);
    mem_chk(AWB'(0), 8'h12);
    results();
  end
endmodule
`default_nettype wire
